//--- include/blc_pkg.sv
// Functional notes
// - coarse 2-bit code selects 1x/2x/4x/8x gain
// - merge gain code and 10-bit code to 13 bits
// - full scale selectable, three choices, 1.07 V default
// - fixed gain forces one gain, 10-bit slice out
// - loop drives 13-bit black level to 64
// - loop sums black error only inside black-pixel window
// - update per line, or every n+10 black pixels
// - loop gain is 2^select/256; n programmable
// - offset range bit: full or half step
// - fixed gain scales loop step 1/8 to 1
// - top nine accumulator bits readable, writable; write clears rest
// - accumulator starts at mid level
// - loop can be disabled, black set by software
// - black is code 8 in 10-bit output at 1x gain
// - loop acquires black over leading frame lines
// - calibration offsets added to 13-bit result
`default_nettype none
package blc_pkg;
    localparam int ADC_W = 10;
    localparam int PIX_W = 13;
    localparam int ACC_W = 17;

    localparam logic [7:0] ADDR_OFFSET_RANGE = 8'h06;
    localparam logic [7:0] ADDR_FULL_SCALE   = 8'h07;
    localparam logic [7:0] ADDR_LOOP_CTRL    = 8'h08;
    localparam logic [7:0] ADDR_BLACK_COUNT  = 8'h09;
    localparam logic [7:0] ADDR_ACC_HI       = 8'h0a;
    localparam logic [7:0] ADDR_ACC_LO       = 8'h0b;
    localparam logic [7:0] ADDR_CAL_A        = 8'h10;
    localparam logic [7:0] ADDR_CAL_B        = 8'h11;
    localparam logic [7:0] ADDR_CAL_C        = 8'h12;
    localparam logic [7:0] ADDR_FIXED_GAIN   = 8'h16;

    localparam logic [7:0] RST_OFFSET_RANGE  = 8'h01;
    localparam logic [7:0] RST_FULL_SCALE    = 8'h01;
    localparam logic [7:0] RST_LOOP_CTRL     = 8'h01;
    localparam logic [7:0] RST_BLACK_COUNT   = 8'h10;
    localparam logic [7:0] RST_CAL           = 8'h00;
    localparam logic [7:0] RST_FIXED_GAIN    = 8'h00;

    localparam int OFFSET_RANGE_BIT = 0;
    localparam int LOOP_EN_BIT      = 0;
    localparam int LOOP_GAIN_LSB    = 1;
    localparam int FIXED_EN_BIT     = 2;

    localparam logic [1:0] FS_ILLEGAL = 2'h3;

    localparam logic [12:0] BLACK_TARGET    = 13'h0040;
    localparam logic [9:0]  BLACK_TARGET_10 = 10'h008;
    localparam logic [16:0] ACC_MID         = 17'h10000;
    localparam logic [16:0] ACC_MAX         = 17'h1ffff;
    localparam logic [7:0]  OB_EXTRA        = 8'h0a;
    localparam logic [7:0]  OB_WAIT_LAST    = OB_EXTRA - 8'h02;

    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_SUM   = 4'b0010,
        S_WAIT  = 4'b0100,
        S_APPLY = 4'b1000
    } loop_state_t;

    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] gain;
        logic [9:0] code;
    } conv_t;

    typedef struct packed {
        logic        valid;
        logic [12:0] data;
    } pix_t;

    // right shift that takes the 13-bit word back to a 10-bit slice
    function automatic logic [1:0] slice_shift(input logic [1:0] gain);
        slice_shift = 2'h3 - gain;
    endfunction : slice_shift
endpackage : blc_pkg
`default_nettype wire

//--- rtl/pix_combine.sv
`default_nettype none
module pix_combine
    import blc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire conv_t      conv_i,
    input  wire logic       fixed_en_i,
    input  wire logic [1:0] fixed_gain_i,
    input  wire logic [7:0] cal_a_i,
    input  wire logic [7:0] cal_b_i,
    input  wire logic [7:0] cal_c_i,
    output var  pix_t       pix_o,
    output logic [9:0]      fixed_out_o
);
    logic [1:0]  gain;
    logic [12:0] shifted;
    logic [7:0]  cal;
    logic [14:0] sum;
    logic [12:0] sat;
    pix_t        pix_d;
    pix_t        pix_q;
    logic [9:0]  fixed_d;
    logic [9:0]  fixed_q;

    always_comb begin
        gain = fixed_en_i ? fixed_gain_i : conv_i.gain;
        shifted = {conv_i.code, 3'h0} >> gain;
        if (gain == 2'h1) begin
            cal = cal_a_i;
        end else if (gain == 2'h2) begin
            cal = cal_b_i;
        end else if (gain == 2'h3) begin
            cal = cal_c_i;
        end else begin
            cal = 8'h00;
        end
        sum = {2'h0, shifted} + {{7{cal[7]}}, cal};
        if (sum[14]) begin
            sat = 13'h0000;
        end else if (sum[13]) begin
            sat = 13'h1fff;
        end else begin
            sat = sum[12:0];
        end
        pix_d.valid = conv_i.valid;
        pix_d.data  = conv_i.valid ? sat : pix_q.data;
        // ten-bit slice of the fixed gain
        fixed_d = conv_i.valid ? 10'(sat >> slice_shift(gain)) : fixed_q;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pix_q   <= '0;
            fixed_q <= 10'h000;
        end else begin
            pix_q   <= pix_d;
            fixed_q <= fixed_d;
        end
    end

    assign pix_o       = pix_q;
    assign fixed_out_o = fixed_q;

    AST_GAIN_UNDO: assert property (@(posedge clk_i) disable iff (rst_i)
        (conv_i.valid && !fixed_en_i && conv_i.gain == 2'h1 && cal_a_i == 8'h00)
        |=> pix_o.data == 13'({$past(conv_i.code), 3'h0} >> 1))
        else $error("gain code 2x not undone by one shift");

    AST_BLACK_TEN: assert property (@(posedge clk_i) disable iff (rst_i)
        (conv_i.valid && fixed_en_i && fixed_gain_i == 2'h0 && conv_i.code == BLACK_TARGET_10)
        |=> pix_o.data == BLACK_TARGET && fixed_out_o == BLACK_TARGET_10)
        else $error("black 64 does not map to 8 at fixed 1x");
endmodule : pix_combine
`default_nettype wire

//--- rtl/black_level_gain.sv
`default_nettype none
module black_level_gain
    import blc_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    input  wire conv_t    conv_i,
    input  wire reg_req_t reg_req_i,
    input  wire logic     clamp_pin_i,
    input  wire logic     clamp_int_i,
    input  wire logic     timing_int_i,
    input  wire logic     ob_line_i,
    output logic [7:0]    reg_rdata_o,
    output var  pix_t     pix_o,
    output logic [9:0]    fixed_out_o,
    output logic [1:0]    vga_gain_o,
    output logic          fixed_mode_o,
    output logic [1:0]    full_scale_o,
    output logic          offset_range_o,
    output logic [8:0]    black_level_o
);
    // register group
    logic [7:0]  offset_range_q, offset_range_d;
    logic [7:0]  full_scale_q,   full_scale_d;
    logic [7:0]  loop_ctrl_q,    loop_ctrl_d;
    logic [7:0]  black_count_q,  black_count_d;
    logic [7:0]  acc_stage_q,    acc_stage_d;
    logic [7:0]  cal_a_q,        cal_a_d;
    logic [7:0]  cal_b_q,        cal_b_d;
    logic [7:0]  cal_c_q,        cal_c_d;
    logic [7:0]  fixed_gain_q,   fixed_gain_d;
    logic [7:0]  rdata_q,        rdata_d;
    logic [1:0]  vga_gain_q,     vga_gain_d;
    // clamp pin synchroniser
    logic        clamp_s1_q, clamp_s2_q, clamp_s3_q;
    logic        clamp_filt_q, clamp_filt_d;
    // loop group
    loop_state_t state_q,   state_d;
    logic [7:0]  cnt_q,     cnt_d;
    logic [21:0] err_sum_q, err_sum_d;
    logic [16:0] acc_q,     acc_d;
    logic [13:0] err;
    logic [24:0] step;
    logic [2:0]  step_shift;
    logic [26:0] acc_wide;
    logic        window;
    logic        loop_en;
    logic        fixed_en;
    logic        acc_wr;
    pix_t        pix;

    assign loop_en  = loop_ctrl_q[LOOP_EN_BIT];
    assign fixed_en = fixed_gain_q[FIXED_EN_BIT];
    assign acc_wr   = reg_req_i.we && reg_req_i.addr == ADDR_ACC_LO;

    pix_combine u_combine (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .conv_i      (conv_i),
        .fixed_en_i  (fixed_en),
        .fixed_gain_i(fixed_gain_q[1:0]),
        .cal_a_i     (cal_a_q),
        .cal_b_i     (cal_b_q),
        .cal_c_i     (cal_c_q),
        .pix_o       (pix),
        .fixed_out_o (fixed_out_o)
    );

    // register writes and reads
    always_comb begin
        offset_range_d = offset_range_q;
        full_scale_d   = full_scale_q;
        loop_ctrl_d    = loop_ctrl_q;
        black_count_d  = black_count_q;
        acc_stage_d    = acc_stage_q;
        cal_a_d        = cal_a_q;
        cal_b_d        = cal_b_q;
        cal_c_d        = cal_c_q;
        fixed_gain_d   = fixed_gain_q;
        rdata_d        = rdata_q;
        if (reg_req_i.we) begin
            if (reg_req_i.addr == ADDR_OFFSET_RANGE) begin
                offset_range_d = reg_req_i.wdata;
            end else if (reg_req_i.addr == ADDR_FULL_SCALE) begin
                if (reg_req_i.wdata[1:0] != FS_ILLEGAL) begin
                    full_scale_d = {6'h00, reg_req_i.wdata[1:0]};
                end
            end else if (reg_req_i.addr == ADDR_LOOP_CTRL) begin
                loop_ctrl_d = {5'h00, reg_req_i.wdata[2:0]};
            end else if (reg_req_i.addr == ADDR_BLACK_COUNT) begin
                black_count_d = reg_req_i.wdata;
            end else if (reg_req_i.addr == ADDR_ACC_HI) begin
                acc_stage_d = reg_req_i.wdata;
            end else if (reg_req_i.addr == ADDR_CAL_A) begin
                cal_a_d = reg_req_i.wdata;
            end else if (reg_req_i.addr == ADDR_CAL_B) begin
                cal_b_d = reg_req_i.wdata;
            end else if (reg_req_i.addr == ADDR_CAL_C) begin
                cal_c_d = reg_req_i.wdata;
            end else if (reg_req_i.addr == ADDR_FIXED_GAIN) begin
                fixed_gain_d = {5'h00, reg_req_i.wdata[2:0]};
            end
        end
        if (reg_req_i.re) begin
            if (reg_req_i.addr == ADDR_OFFSET_RANGE) begin
                rdata_d = offset_range_q;
            end else if (reg_req_i.addr == ADDR_FULL_SCALE) begin
                rdata_d = full_scale_q;
            end else if (reg_req_i.addr == ADDR_LOOP_CTRL) begin
                rdata_d = loop_ctrl_q;
            end else if (reg_req_i.addr == ADDR_BLACK_COUNT) begin
                rdata_d = black_count_q;
            end else if (reg_req_i.addr == ADDR_ACC_HI) begin
                rdata_d = acc_q[16:9];
            end else if (reg_req_i.addr == ADDR_ACC_LO) begin
                rdata_d = {7'h00, acc_q[8]};
            end else if (reg_req_i.addr == ADDR_CAL_A) begin
                rdata_d = cal_a_q;
            end else if (reg_req_i.addr == ADDR_CAL_B) begin
                rdata_d = cal_b_q;
            end else if (reg_req_i.addr == ADDR_CAL_C) begin
                rdata_d = cal_c_q;
            end else if (reg_req_i.addr == ADDR_FIXED_GAIN) begin
                rdata_d = fixed_gain_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
        vga_gain_d = fixed_en ? fixed_gain_q[1:0] : conv_i.gain;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            offset_range_q <= RST_OFFSET_RANGE;
            full_scale_q   <= RST_FULL_SCALE;
            loop_ctrl_q    <= RST_LOOP_CTRL;
            black_count_q  <= RST_BLACK_COUNT;
            acc_stage_q    <= 8'h00;
            cal_a_q        <= RST_CAL;
            cal_b_q        <= RST_CAL;
            cal_c_q        <= RST_CAL;
            fixed_gain_q   <= RST_FIXED_GAIN;
            rdata_q        <= 8'h00;
            vga_gain_q     <= 2'h0;
        end else begin
            offset_range_q <= offset_range_d;
            full_scale_q   <= full_scale_d;
            loop_ctrl_q    <= loop_ctrl_d;
            black_count_q  <= black_count_d;
            acc_stage_q    <= acc_stage_d;
            cal_a_q        <= cal_a_d;
            cal_b_q        <= cal_b_d;
            cal_c_q        <= cal_c_d;
            fixed_gain_q   <= fixed_gain_d;
            rdata_q        <= rdata_d;
            vga_gain_q     <= vga_gain_d;
        end
    end

    // clamp pin: change taken once second and third stages agree
    always_comb begin
        clamp_filt_d = (clamp_s2_q == clamp_s3_q) ? clamp_s3_q : clamp_filt_q;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clamp_s1_q   <= 1'b0;
            clamp_s2_q   <= 1'b0;
            clamp_s3_q   <= 1'b0;
            clamp_filt_q <= 1'b0;
        end else begin
            clamp_s1_q   <= clamp_pin_i;
            clamp_s2_q   <= clamp_s1_q;
            clamp_s3_q   <= clamp_s2_q;
            clamp_filt_q <= clamp_filt_d;
        end
    end

    // window from pin or internal timing
    assign window = timing_int_i ? clamp_int_i : clamp_filt_q;

    // black-level loop
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        err_sum_d = err_sum_q;
        acc_d     = acc_q;
        err = {1'b0, BLACK_TARGET} - {1'b0, pix.data};
        // loop gain 1, 2, 4 or 8 over 256
        step = 25'({{3{err_sum_q[21]}}, err_sum_q} << loop_ctrl_q[LOOP_GAIN_LSB +: 2]);
        step_shift = {2'h0, ~offset_range_q[OFFSET_RANGE_BIT]}
                   + (fixed_en ? {1'b0, slice_shift(fixed_gain_q[1:0])} : 3'h0);
        acc_wide = {10'h000, acc_q} + 27'($signed({{2{step[24]}}, step}) >>> step_shift);
        case (state_q)
            S_IDLE: begin
                if (window) begin
                    state_d   = S_SUM;
                    cnt_d     = 8'h00;
                    err_sum_d = 22'h000000;
                end
            end
            S_SUM: begin
                if (!window) begin
                    state_d = ob_line_i ? S_IDLE : S_APPLY;
                end else if (black_count_q == 8'h00) begin
                    state_d = S_WAIT;
                end else if (pix.valid) begin
                    err_sum_d = err_sum_q + {{8{err[13]}}, err};
                    if (cnt_q == black_count_q - 8'h01) begin
                        state_d = S_WAIT;
                        cnt_d   = 8'h00;
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end
            end
            S_WAIT: begin
                if (!window) begin
                    state_d = ob_line_i ? S_IDLE : S_APPLY;
                end else if (ob_line_i && pix.valid) begin
                    if (cnt_q == OB_WAIT_LAST) begin
                        state_d = S_APPLY;
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end
            end
            S_APPLY: begin
                if (acc_wide[26]) begin
                    acc_d = 17'h00000;
                end else if (acc_wide[25:17] != 9'h000) begin
                    acc_d = ACC_MAX;
                end else begin
                    acc_d = acc_wide[16:0];
                end
                // keep running over leading black lines
                state_d   = (window && ob_line_i) ? S_SUM : S_IDLE;
                cnt_d     = 8'h00;
                err_sum_d = 22'h000000;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
        if (!loop_en) begin
            state_d = S_IDLE;
            acc_d   = acc_q;
        end
        // write sets top bits, clears the rest
        if (acc_wr) begin
            acc_d = {acc_stage_q, reg_req_i.wdata[0], 8'h00};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q   <= S_IDLE;
            cnt_q     <= 8'h00;
            err_sum_q <= 22'h000000;
            acc_q     <= ACC_MID;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            err_sum_q <= err_sum_d;
            acc_q     <= acc_d;
        end
    end

    assign reg_rdata_o    = rdata_q;
    assign pix_o          = pix;
    assign vga_gain_o     = vga_gain_q;
    assign fixed_mode_o   = fixed_en;
    assign full_scale_o   = full_scale_q[1:0];
    assign offset_range_o = offset_range_q[OFFSET_RANGE_BIT];
    assign black_level_o  = acc_q[16:8];

    AST_ACC_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        acc_wr |=> acc_q == {$past(acc_stage_q), $past(reg_req_i.wdata[0]), 8'h00})
        else $error("accumulator write did not load top bits and clear the rest");

    AST_ACC_SAT: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_APPLY && loop_en && !acc_wr && !acc_wide[26] && acc_wide[25:17] != 9'h000)
        |=> acc_q == ACC_MAX)
        else $error("accumulator wrapped instead of saturating high");

    AST_LOOP_OFF_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (!loop_en && !acc_wr) |=> acc_q == $past(acc_q))
        else $error("accumulator moved with the loop disabled");

    AST_UPDATE_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(acc_q) |-> ($past(acc_wr) || $past(state_q) == S_APPLY))
        else $error("accumulator changed without a window update or write");

    AST_OB_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_WAIT && loop_en && window && ob_line_i && pix.valid
         && cnt_q == OB_WAIT_LAST) |=> state_q == S_APPLY ##1 state_q != S_APPLY)
        else $error("black-line update not taken at n plus ten pixels");

    AST_LINE_UPDATE: assert property (@(posedge clk_i) disable iff (rst_i)
        ((state_q == S_SUM || state_q == S_WAIT) && loop_en && !window && !ob_line_i)
        |=> state_q == S_APPLY)
        else $error("active-line update missing at window end");

    AST_FULL_SCALE: assert property (@(posedge clk_i) disable iff (rst_i)
        (reg_req_i.we && reg_req_i.addr == ADDR_FULL_SCALE
         && reg_req_i.wdata[1:0] == FS_ILLEGAL) |=> $stable(full_scale_o))
        else $error("illegal full-scale code accepted");

    AST_FIXED_FORCE: assert property (@(posedge clk_i) disable iff (rst_i)
        fixed_en |=> vga_gain_o == $past(fixed_gain_q[1:0]))
        else $error("fixed gain not forced onto the amplifier");

    AST_SUM_IN_WINDOW: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_SUM && window && pix.valid && black_count_q != 8'h00)
        |=> err_sum_q == $past(err_sum_q) + {{8{$past(err[13])}}, $past(err)})
        else $error("black error not accumulated against code 64");
endmodule : black_level_gain
`default_nettype wire

//--- dv/ccd_model.sv
`default_nettype none
module ccd_model
    import blc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic [7:0] len_i,
    output var  conv_t      conv_o,
    output logic            window_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] cnt_q;
    logic [8:0] cnt_d;
    logic       pix_on;

    always_comb begin
        cnt_d = cnt_q;
        if (start_i) begin
            cnt_d = {1'b0, len_i} + 9'h003;
        end else if (cnt_q != 9'h000) begin
            cnt_d = cnt_q - 9'h001;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 9'h000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign window_o = (cnt_q != 9'h000);
    assign pix_on = (cnt_q >= 9'h003) && (cnt_q <= {1'b0, len_i} + 9'h002);
    // code toggles between pixels so stale data never looks black
    assign conv_o = '{valid: pix_on, gain: 2'h0, code: pix_on ? 10'h000 : {10{cnt_q[0]}}};
endmodule : ccd_model
`default_nettype wire

//--- dv/testbench.sv
`default_nettype none
module testbench
    import blc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    reg_req_t    req   = '0;
    conv_t       tconv = '0;
    conv_t       mconv;
    conv_t       conv;
    logic        tmg   = 1'b0;
    logic        ob    = 1'b0;
    logic        start = 1'b0;
    logic [7:0]  len   = 8'h00;
    logic        win;
    logic [7:0]  rdata;
    pix_t        pix;
    logic [9:0]  fout;
    logic [1:0]  vga;
    logic [1:0]  fs;
    logic        fm;
    logic        orng;
    logic [8:0]  lvl;
    logic [8:0]  old;
    int          miscompares = 0;
    int          checked = 0;
    int          gap;
    logic [24:0] rows [5] = '{{2'h0, 10'h2cd, 13'h1668}, {2'h1, 10'h23e, 13'h08f8},
        {2'h2, 10'h3ff, 13'h07fe}, {2'h3, 10'h001, 13'h0001}, {2'h0, 10'h008, 13'h0040}};
    logic [15:0] regs [11] = '{16'h0601, 16'h0701, 16'h0801, 16'h0910, 16'h1000, 16'h1100,
        16'h1200, 16'h1600, 16'h0a80, 16'h0b00, 16'h2000};

    always #25 clk_i = ~clk_i;
    assign conv = win ? mconv : tconv;

    ccd_model mdl (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .len_i(len),
        .conv_o(mconv), .window_o(win));
    black_level_gain dut (.clk_i(clk_i), .rst_i(rst_i), .conv_i(conv), .reg_req_i(req),
        .clamp_pin_i(win & ~tmg), .clamp_int_i(win & tmg), .timing_int_i(tmg),
        .ob_line_i(ob), .reg_rdata_o(rdata), .pix_o(pix), .fixed_out_o(fout),
        .vga_gain_o(vga), .fixed_mode_o(fm), .full_scale_o(fs), .offset_range_o(orng),
        .black_level_o(lvl));

    task automatic chk_val(input logic [12:0] got, input logic [12:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_val

    task automatic chk_pix(input logic [12:0] exp);
        chk_val({12'h000, pix.valid}, 13'h0001, "pixel valid");
        chk_val(pix.data, exp, "pixel data");
    endtask : chk_pix

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        #2 req.we = 1'b0;
        @(posedge clk_i);
        #2;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        #2 req.re = 1'b0;
        @(posedge clk_i);
        #2 chk_val({5'h00, rdata}, {5'h00, exp}, "register read");
    endtask : rd

    task automatic px(input logic [1:0] g, input logic [9:0] c, input logic [12:0] exp);
        tconv = '{valid: 1'b1, gain: g, code: c};
        @(posedge clk_i);
        #2 tconv.valid = 1'b0;
        chk_pix(exp);
        @(posedge clk_i);
        #2;
    endtask : px

    task automatic kick(input logic [7:0] n, input logic sel);
        tmg = sel;
        len = n;
        start = 1'b1;
        @(posedge clk_i);
        #2 start = 1'b0;
    endtask : kick

    task automatic burst(input logic sel, input logic [8:0] exp);
        kick(8'h0c, sel);
        repeat (24) @(posedge clk_i);
        #2 chk_val({4'h0, lvl}, {4'h0, exp}, "black level");
    endtask : burst

    task automatic setacc(input logic [7:0] hi, input logic b);
        wr(8'h0a, hi);
        wr(8'h0b, {7'h00, b});
    endtask : setacc

    task automatic stop_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (6000) @(posedge clk_i);
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        #2 rst_i = 1'b0;
        chk_val({4'h0, lvl}, 13'h0100, "mid level");
        chk_val({12'h000, orng}, 13'h0001, "offset range");
        for (int i = 0; i < 11; i++) rd(regs[i][15:8], regs[i][7:0]);
        for (int i = 0; i < 5; i++) begin
            px(rows[i][24:23], rows[i][22:13], rows[i][12:0]);
            chk_val({11'h000, vga}, {11'h000, rows[i][24:23]}, "coarse gain");
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h07, i[7:0]);
            chk_val({11'h000, fs}, (i == 3) ? 13'h0002 : i[12:0], "full scale");
        end
        wr(8'h07, 8'h01);
        wr(8'h10, 8'h05);
        px(2'h1, 10'h23e, 13'h08fd);
        wr(8'h12, 8'hff);
        px(2'h3, 10'h000, 13'h0000);
        wr(8'h10, 8'h00);
        wr(8'h12, 8'h00);
        for (int g = 0; g < 4; g++) begin
            wr(8'h16, {6'h01, g[1:0]});
            px(~g[1:0], 10'h155, 13'h0aa8 >> g);
            chk_val({3'h0, fout}, 13'h0155, "fixed slice");
            chk_val({10'h000, fm, vga}, {11'h001, g[1:0]}, "fixed gain");
            if (g == 0) begin
                px(2'h2, 10'h008, 13'h0040);
                chk_val({3'h0, fout}, 13'h0008, "black in ten bits");
            end
        end
        wr(8'h16, 8'h00);
        wr(8'h09, 8'h04);
        setacc(8'h80, 1'b0);
        burst(1'b0, 9'h101);
        wr(8'h06, 8'h00);
        chk_val({12'h000, orng}, 13'h0000, "offset range");
        burst(1'b1, 9'h101);
        burst(1'b1, 9'h102);
        wr(8'h06, 8'h01);
        wr(8'h08, 8'h07);
        burst(1'b1, 9'h10a);
        wr(8'h16, 8'h04);
        burst(1'b1, 9'h10b);
        wr(8'h16, 8'h00);
        wr(8'h08, 8'h06);
        burst(1'b1, 9'h10b);
        wr(8'h08, 8'h07);
        setacc(8'hff, 1'b1);
        burst(1'b1, 9'h1ff);
        setacc(8'ha5, 1'b1);
        chk_val({4'h0, lvl}, 13'h014b, "written level");
        rd(8'h0a, 8'ha5);
        rd(8'h0b, 8'h01);
        wr(8'h08, 8'h01);
        setacc(8'h80, 1'b0);
        ob = 1'b1;
        kick(8'hc8, 1'b1);
        old = lvl;
        for (int i = 0; i < 60 && lvl === old; i++) begin
            @(posedge clk_i);
            #2;
        end
        old = lvl;
        gap = 0;
        for (int i = 0; i < 60 && lvl === old; i++) begin
            @(posedge clk_i);
            #2 gap++;
        end
        chk_val(gap[12:0], 13'h000e, "black line period");
        repeat (220) @(posedge clk_i);
        #2 ob = 1'b0;
        // mid-run reset must bring back the power-up state
        rst_i = 1'b1;
        @(posedge clk_i);
        #2 rst_i = 1'b0;
        chk_val({4'h0, lvl}, 13'h0100, "mid level after reset");
        rd(8'h09, 8'h10);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
